// ---- dv/bis_bus_model.sv ----
// bis_bus_model.sv: far-side bus master framing bytes on the two lines.
// assumes the bench resolves open-drain lines with pull-ups; 160 ns per bit.
`timescale 1ns/10ps
// ======================================================================
// model
module bis_bus_model (
    input wire scl_line_i, // resolved clock line
    output logic scl_rel_o, // 1 = clock released
    output logic sda_rel_o, // 1 = data released
    output logic stuck_o // a held clock never came back
);
    // idle bus: both lines released, clock stands still between frames
    initial begin
        scl_rel_o = 1'b1;
        sda_rel_o = 1'b1;
        stuck_o = 1'b0;
    end
    // release the clock and wait out a stretched low, bounded
    task automatic rise_scl();
        int n;
        scl_rel_o = 1'b1;
        n = 0;
        while (scl_line_i !== 1'b1 && n < 500) begin
            #4;
            n++;
        end
        if (n == 500)
            stuck_o = 1'b1;
    endtask
    // one bit, entered and left with the clock low
    task automatic put_bit(input logic b);
        sda_rel_o = b;
        #40;
        rise_scl();
        #80;
        scl_rel_o = 1'b0;
        #40;
    endtask
    task automatic start_c();
        sda_rel_o = 1'b0;
        #80;
        scl_rel_o = 1'b0;
        #40;
    endtask
    task automatic restart_c();
        sda_rel_o = 1'b1;
        #40;
        rise_scl();
        #40;
        sda_rel_o = 1'b0;
        #40;
        scl_rel_o = 1'b0;
        #40;
    endtask
    task automatic stop_c();
        sda_rel_o = 1'b0;
        #40;
        rise_scl();
        #40;
        sda_rel_o = 1'b1;
        #80;
    endtask
    // msb first; ack low only when this side stands in for the addressed slave
    task automatic send_byte(input logic [7:0] b, input logic ack);
        for (int i = 7; i >= 0; i--)
            put_bit(b[i]);
        put_bit(!ack);
    endtask
endmodule // bis_bus_model

// ---- dv/bis_i2c_irq_props.sv ----
// bis_i2c_irq_props.sv: port properties of the bus interrupt block.
// assumes the ports of bis_i2c_irq; bound at the foot of this file.
`timescale 1ns/10ps
// ======================================================================
// checker
module bis_i2c_irq_props (
    input wire clock_i, // clock
    input wire arst_n_i, // reset
    input wire scl_i, // clock line
    input wire sda_i, // data line
    input wire scl_oe_n_o, // clock hold
    input wire [1:0] reg_addr_i, // offset
    input wire [7:0] reg_wdata_i, // write data
    input wire reg_wr_i, // write strobe
    input wire reg_rd_i, // read strobe
    input wire [7:0] reg_rdata_o, // read data
    input wire bus_event_irq_o // interrupt
);
    reg stop_en_q;
    // shadow of the stop enable, since the checker sees only register writes
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i)
            stop_en_q <= 1'b0;
        else if (reg_wr_i && reg_addr_i == 2'h0)
            stop_en_q <= reg_wdata_i[4];
    end
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);
    property p_irq_gap;
        bus_event_irq_o |=> (!bus_event_irq_o) [*8];
    endproperty
    a_irq_gap: assert property (p_irq_gap) else $error("interrupt pulse too long");
    property p_hold_at_irq;
        bus_event_irq_o && !scl_i |-> !scl_oe_n_o;
    endproperty
    a_hold_at_irq: assert property (p_hold_at_irq) else $error("byte interrupt without hold");
    property p_hold_cause;
        $fell(scl_oe_n_o) |-> bus_event_irq_o;
    endproperty
    a_hold_cause: assert property (p_hold_cause) else $error("hold without interrupt");
    property p_release;
        reg_wr_i && (reg_addr_i == 2'h3 || reg_addr_i == 2'h0 && reg_wdata_i[5]) |-> ##2 scl_oe_n_o;
    endproperty
    a_release: assert property (p_release) else $error("hold not released");
    property p_stop_irq;
        $rose(sda_i) && scl_i && stop_en_q |-> ##[1:8] bus_event_irq_o;
    endproperty
    a_stop_irq: assert property (p_stop_irq) else $error("no stop interrupt");
    property p_stop_quiet;
        $rose(sda_i) && scl_i && !stop_en_q |=> (!bus_event_irq_o) [*8];
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("stop interrupt while disabled");
    property p_stop_no_hold;
        bus_event_irq_o && scl_i |-> scl_oe_n_o;
    endproperty
    a_stop_no_hold: assert property (p_stop_no_hold) else $error("hold at stop");
    property p_rdata_idle;
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
    c_byte_irq: cover property (bus_event_irq_o && !scl_i);
    c_stop_irq: cover property (bus_event_irq_o && scl_i);
    c_release: cover property ($rose(scl_oe_n_o));
endmodule // bis_i2c_irq_props

bind bis_i2c_irq bis_i2c_irq_props i_props (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .scl_i(scl_i), .sda_i(sda_i), .scl_oe_n_o(scl_oe_n_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .bus_event_irq_o(bus_event_irq_o)
);

// ---- dv/tb.sv ----
// tb.sv: self-checking bench of the bus interrupt and status block.
// assumes a 250 MHz clock and the far-side model on the two lines.
`timescale 1ns/10ps
// ======================================================================
// bench
module tb;
    logic clock_i;
    logic arst_n_i;
    logic master_mode_i;
    logic [1:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [7:0] ctl;
    logic [7:0] seen[$];
    int bad_count;
    int n_compared;
    wire scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, scl_rel, sda_rel, stuck, bus_event_irq_o;
    wire [7:0] reg_rdata_o;
    // open-drain lines: any party pulling low wins, else the pull-up
    wire scl_line = scl_rel & (scl_oe_n_o | scl_o);
    wire sda_line = sda_rel & (sda_oe_n_o | sda_o);
    bis_i2c_irq i_bis_i2c_irq (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .master_mode_i(master_mode_i), .scl_i(scl_line),
        .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .bus_event_irq_o(bus_event_irq_o)
    );
    bis_bus_model i_bis_bus_model (.scl_line_i(scl_line), .scl_rel_o(scl_rel), .sda_rel_o(sda_rel), .stuck_o(stuck));
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        @(posedge clock_i);
        d = reg_rdata_o;
    endtask
    // each interrupt served at once: status read, then the wait released
    initial begin : serve
        logic [7:0] s;
        forever begin
            @(posedge clock_i);
            if (bus_event_irq_o === 1'b1) begin
                reg_read(2'h1, s);
                seen.push_back(s);
                reg_write(2'h0, ctl | 8'h20);
            end
        end
    end
    // one frame; 256 marks a restart; e holds {status, care mask} per interrupt
    task automatic frame(input logic [7:0] c, input logic mm, input int b[$], input logic [15:0] e[$]);
        ctl = c;
        seen.delete();
        reg_write(2'h0, c);
        master_mode_i <= mm;
        #1;
        i_bis_bus_model.start_c();
        foreach (b[k]) begin
            if (b[k] == 256)
                i_bis_bus_model.restart_c();
            else
                i_bis_bus_model.send_byte(b[k][7:0], mm);
        end
        i_bis_bus_model.stop_c();
        repeat (30) @(posedge clock_i);
        if (stuck === 1'b1) begin
            bad_count++;
            wrap_up();
        end
        chk(16'(seen.size()), 16'(e.size()));
        foreach (e[k]) chk({8'h00, seen[k] & e[k][7:0]}, {8'h00, e[k][15:8] & e[k][7:0]});
    endtask
    // reset values, read-only status, unused control and address bits
    task automatic t_regs();
        logic [7:0] d;
        logic [7:0] rb [3] = '{8'h1c, 8'h00, 8'hfe};
        for (int a = 0; a < 4; a++) begin
            reg_read(2'(a), d);
            chk({8'h00, d}, 16'h0000);
        end
        for (int a = 0; a < 3; a++) begin
            reg_write(2'(a), 8'hff);
            reg_read(2'(a), d);
            chk({8'h00, d}, {8'h00, rb[a]});
        end
        reg_write(2'h2, 8'h74);
    endtask
    // the data register keeps the last byte of the frame after the stop
    task automatic t_slave8();
        logic [7:0] d;
        frame(8'h14, 1'b0, '{8'h74, 8'h5a, 8'ha5}, '{16'h16f7, 16'h10f7, 16'h10f7, 16'h01ff});
        reg_read(2'h3, d);
        chk({8'h00, d}, 16'h00a5);
    endtask
    task automatic t_slave9();
        frame(8'h0c, 1'b0, '{8'h74, 8'h3c, 8'hc3}, '{16'h16f7, 16'h14f7, 16'h10f3});
    endtask
    task automatic t_rst_match();
        frame(8'h1c, 1'b0, '{8'h74, 8'h11, 256, 8'h74, 8'h22},
              '{16'h16f7, 16'h10f3, 16'h16f7, 16'h10f3, 16'h01ff});
    endtask
    task automatic t_rst_ext8();
        frame(8'h14, 1'b0, '{8'h74, 8'h11, 256, 8'h0a, 8'h22},
              '{16'h16f7, 16'h10f7, 16'h22f7, 16'h20f7, 16'h01ff});
    endtask
    task automatic t_rst_miss();
        // ack enable off: the address is still answered, the data byte is not
        frame(8'h08, 1'b0, '{8'h74, 8'h11, 256, 8'h44, 8'h22}, '{16'h16f7, 16'h10f7, 16'h02fb});
    endtask
    task automatic t_ext9();
        frame(8'h1c, 1'b0, '{8'h0a, 8'h33, 8'h55, 256, 8'h74, 8'h44},
              '{16'h22f7, 16'h26f7, 16'h24f7, 16'h20f3, 16'h16f7, 16'h10f3, 16'h01ff});
    endtask
    task automatic t_mst8();
        frame(8'h04, 1'b1, '{8'h22, 8'h5a, 8'ha5}, '{16'h86c7, 16'h80c7, 16'h80c3});
    endtask
    task automatic t_mst9();
        frame(8'h1c, 1'b1, '{8'h22, 8'h5a, 8'h5b, 256, 8'h0a, 8'h66, 8'h67},
              '{16'h86c7, 16'h84c7, 16'h80c3, 16'ha6f7, 16'ha4f7, 16'ha0f3, 16'h01ff});
    endtask
    // reset for 8 cycles, let the line synchronisers settle, then the scenarios
    initial begin
        arst_n_i = 1'b0;
        master_mode_i = 1'b0;
        reg_addr_i = 2'h0;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        ctl = 8'h00;
        bad_count = 0;
        n_compared = 0;
        repeat (8) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        t_regs();
        t_slave8();
        t_slave9();
        t_rst_match();
        t_rst_ext8();
        t_rst_miss();
        t_ext9();
        t_mst8();
        t_mst9();
        wrap_up();
    end
endmodule // tb

// ---- verilog/bis_cond.v ----
// bis_cond.v: finds serial clock edges and start and stop conditions.
// assumes synchronised line levels on the same clock.
`timescale 1ns/10ps

module bis_cond (
    input wire clock_i,     // system clock
    input wire arst_n_i,    // async reset, active low
    input wire scl_i,       // synchronised clock line
    input wire sda_i,       // synchronised data line
    output wire scl_rise_o, // clock line rose, one cycle
    output wire scl_fall_o, // clock line fell, one cycle
    output wire start_o,    // start or restart seen, one cycle
    output wire stop_o      // stop seen, one cycle
);

    reg scl_q;
    reg sda_q;

    // ==========================================================================
    // previous levels for edge finding
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // data moving while the clock stays high marks a condition
    assign scl_rise_o = scl_i & ~scl_q;
    assign scl_fall_o = ~scl_i & scl_q;
    assign start_o = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_o = scl_i & scl_q & ~sda_q & sda_i;

endmodule // bis_cond

// ---- verilog/bis_defs.vh ----
// bis_defs.vh: register offsets, field positions, reset values and bit counts
// of the bus interrupt and status block.
// assumes inclusion by its bare name from the design files of the block.
`ifndef BIS_DEFS_VH
`define BIS_DEFS_VH

// ==========================================================================
// register offsets on the plain register port
`define BIS_OFF_CTRL 2'h0
`define BIS_OFF_STAT 2'h1
`define BIS_OFF_SADDR 2'h2
`define BIS_OFF_DATA 2'h3

// ==========================================================================
// bus_control_reg fields
`define BIS_CTRL_WREL 5
`define BIS_CTRL_SPIE 4
`define BIS_CTRL_WTIM 3
`define BIS_CTRL_ACKE 2
`define BIS_CTRL_MASK 8'h1c

// ==========================================================================
// bus_status_reg fields
`define BIS_STAT_MSTS 7
`define BIS_STAT_ALD 6
`define BIS_STAT_EXC 5
`define BIS_STAT_COI 4
`define BIS_STAT_TRC 3
`define BIS_STAT_ACKD 2
`define BIS_STAT_STD 1
`define BIS_STAT_SPD 0

// ==========================================================================
// reset values
`define BIS_CTRL_RST 8'h00
`define BIS_SADDR_RST 8'h00
`define BIS_DATA_RST 8'h00

// ==========================================================================
// serial clock counts within one byte
`define BIS_CNT_EIGHTH 4'h8
`define BIS_CNT_NINTH 4'h9

`endif

// ---- verilog/bis_i2c_irq.v ----
// bis_i2c_irq.v: interrupt and status generation of a two-wire bus channel.
// assumes an own master engine outside reports master operation on master_mode_i,
// and that software serves each bus_event_irq pulse before the next byte.
`timescale 1ns/10ps
`include "bis_defs.vh"

// Overview of operation
// - every interrupt comes with a defined status held until serviced
// - stop gives status 00000001 and interrupt only with stop enable
// - master: 10XXX110 at address, 10XXX000 at data, 10XXXX00 last
// - master ninth-clock timing: data reads 10XXX100, one interrupt per byte
// - master restart ninth-clock: 10XXX110 per address, 10XXXX00 per data
// - master extension code: 1010X110, 1010X000, 1010XX00 at last
// - master extension code ninth-clock: data reads 1010X100
// - matched slave eighth-clock: 0001X110 at address, 0001X000 at data
// - matched slave ninth-clock: 0001X100 data, 0001XX00 final
// - restart with own address again: 0001X110 and continue matched
// - restart with extension code: 0010X010 then 0010X000 for data
// - restart with foreign address: one 00000X10 interrupt, then silence
// - extension code slave eighth-clock: 0010X010 then 0010X000
// - extension code slave ninth-clock: 0010X010, 0010X110, 0010X100, 0010XX00
// - extension then restart with own address: matched status 0001X110
// - timing select picks eighth or ninth clock for wait and interrupt on data bytes
// - start detection sets start flag in status bit 1
// - stop sets status bit 0; interrupt only when control bit 4 set
// - status bit 3 shows transmit direction after eighth address bit
module bis_i2c_irq (
    input wire clock_i,            // system clock, 250 MHz
    input wire arst_n_i,           // async reset, active low
    input wire master_mode_i,      // own master engine drives this transfer
    input wire scl_i,              // clock line level
    output wire scl_o,             // clock line drive value, always low
    output wire scl_oe_n_o,        // clock line drive enable, active low
    input wire sda_i,              // data line level
    output wire sda_o,             // data line drive value, always low
    output wire sda_oe_n_o,        // data line drive enable, active low
    input wire [1:0] reg_addr_i,   // register offset
    input wire [7:0] reg_wdata_i,  // register write data
    input wire reg_wr_i,           // write strobe
    input wire reg_rd_i,           // read strobe
    output wire [7:0] reg_rdata_o, // read data, cycle after the strobe
    output wire bus_event_irq_o    // bus event interrupt, one-cycle pulse
);

    // transfer kinds of the current frame
    localparam [2:0] KIND_NONE = 3'h0;
    localparam [2:0] KIND_MASTER = 3'h1;
    localparam [2:0] KIND_MATCH = 3'h2;
    localparam [2:0] KIND_EXT = 3'h3;
    localparam [2:0] KIND_MISS = 3'h4;

    // ==========================================================================
    // extension code: first address nibble all zero or all one
    function is_ext;
        input [6:0] addr;
        begin
            is_ext = (addr[6:3] == 4'h0) | (addr[6:3] == 4'hf);
        end
    endfunction

    wire [1:0] line_sync;
    wire scl_s;
    wire sda_s;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;

    reg [7:0] ctrl_q;
    reg [7:0] saddr_q;
    reg [7:0] shift_q;
    reg [7:0] rx_data_q;
    reg [7:0] rdata_q;
    reg [3:0] cnt_q;
    reg [2:0] kind_q;
    reg addr_phase_q;
    reg mst_q;
    reg exc_q;
    reg coi_q;
    reg trc_q;
    reg ackd_q;
    reg std_q;
    reg spd_q;
    reg hold_q;
    reg ack_drv_q;
    reg irq_q;

    wire wtim;
    wire spie;
    wire acke;
    wire release_wait;
    wire [7:0] status;
    wire involved;

    // ==========================================================================
    // line synchroniser and condition finder
    bis_sync u_sync (
        .clock_i (clock_i),
        .arst_n_i (arst_n_i),
        .async_i ({scl_i, sda_i}),
        .sync_o (line_sync)
    );

    assign scl_s = line_sync[1];
    assign sda_s = line_sync[0];

    bis_cond u_cond (
        .clock_i (clock_i),
        .arst_n_i (arst_n_i),
        .scl_i (scl_s),
        .sda_i (sda_s),
        .scl_rise_o (scl_rise),
        .scl_fall_o (scl_fall),
        .start_o (start_det),
        .stop_o (stop_det)
    );

    assign wtim = ctrl_q[`BIS_CTRL_WTIM];
    assign spie = ctrl_q[`BIS_CTRL_SPIE];
    assign acke = ctrl_q[`BIS_CTRL_ACKE];
    assign involved = (kind_q == KIND_MASTER) | (kind_q == KIND_MATCH) | (kind_q == KIND_EXT);

    // wait ends on the release bit or on any write of the data register
    assign release_wait = reg_wr_i & (((reg_addr_i == `BIS_OFF_CTRL) & reg_wdata_i[`BIS_CTRL_WREL])
                                      | (reg_addr_i == `BIS_OFF_DATA));

    // ==========================================================================
    // status assembly; arbitration is handled elsewhere, so its bit reads zero
    assign status = {mst_q, 1'b0, exc_q, coi_q, trc_q, ackd_q, std_q, spd_q};

    // ==========================================================================
    // control and own address registers, read data one cycle later
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= `BIS_CTRL_RST;
            saddr_q <= `BIS_SADDR_RST;
            rdata_q <= 8'h00;
        end else begin
            if (reg_wr_i && reg_addr_i == `BIS_OFF_CTRL) begin
                ctrl_q <= reg_wdata_i & `BIS_CTRL_MASK; // release bit is a pulse, never stored
            end
            if (reg_wr_i && reg_addr_i == `BIS_OFF_SADDR) begin
                saddr_q <= {reg_wdata_i[7:1], 1'b0};
            end
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `BIS_OFF_CTRL: rdata_q <= ctrl_q;
                    `BIS_OFF_STAT: rdata_q <= status; // reading has no side effect
                    `BIS_OFF_SADDR: rdata_q <= saddr_q;
                    default: rdata_q <= rx_data_q;
                endcase
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    // ==========================================================================
    // bit counter and shifter; sampled on clock rise, events on clock fall
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift_q <= 8'h00;
            rx_data_q <= `BIS_DATA_RST;
            cnt_q <= 4'h0;
            addr_phase_q <= 1'b0;
        end else if (start_det || stop_det) begin
            cnt_q <= 4'h0;
            addr_phase_q <= start_det;
        end else if (scl_rise && cnt_q != `BIS_CNT_NINTH) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q != `BIS_CNT_EIGHTH) begin
                shift_q <= {shift_q[6:0], sda_s};
            end
        end else if (scl_fall && cnt_q == `BIS_CNT_EIGHTH) begin
            rx_data_q <= shift_q;
        end else if (scl_fall && cnt_q == `BIS_CNT_NINTH) begin
            cnt_q <= 4'h0;
            addr_phase_q <= 1'b0;
        end
    end

    // ==========================================================================
    // transfer kind, status flags, wait hold, acknowledge drive and interrupt
    // status changes only at these protocol points, so it stays stable while
    // the clock line is held and software reads it
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            kind_q <= KIND_NONE;
            mst_q <= 1'b0;
            exc_q <= 1'b0;
            coi_q <= 1'b0;
            trc_q <= 1'b0;
            ackd_q <= 1'b0;
            std_q <= 1'b0;
            spd_q <= 1'b0;
            hold_q <= 1'b0;
            ack_drv_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            irq_q <= 1'b0;
            if (release_wait) begin
                hold_q <= 1'b0;
            end
            if (stop_det) begin
                // stop clears the frame and leaves 00000001
                kind_q <= KIND_NONE;
                mst_q <= 1'b0;
                exc_q <= 1'b0;
                coi_q <= 1'b0;
                trc_q <= 1'b0;
                ackd_q <= 1'b0;
                std_q <= 1'b0;
                spd_q <= 1'b1;
                hold_q <= 1'b0;
                ack_drv_q <= 1'b0;
                irq_q <= spie;
            end else if (start_det) begin
                // a restart keeps the kind so a later mismatch can be reported
                mst_q <= master_mode_i;
                exc_q <= 1'b0;
                coi_q <= 1'b0;
                ackd_q <= 1'b0;
                std_q <= 1'b1;
                spd_q <= 1'b0;
                hold_q <= 1'b0;
                ack_drv_q <= 1'b0;
            end else if (scl_rise && cnt_q == `BIS_CNT_EIGHTH) begin
                ackd_q <= ~sda_s; // ninth bit: acknowledge seen
            end else if (scl_fall && cnt_q == `BIS_CNT_EIGHTH) begin
                ackd_q <= 1'b0;
                if (addr_phase_q) begin
                    if (mst_q) begin
                        kind_q <= KIND_MASTER;
                        exc_q <= is_ext(shift_q[7:1]);
                        trc_q <= ~shift_q[0];
                    end else if (shift_q[7:1] == saddr_q[7:1]) begin
                        kind_q <= KIND_MATCH;
                        coi_q <= 1'b1;
                        trc_q <= shift_q[0];
                        ack_drv_q <= 1'b1; // own address always answered
                    end else if (is_ext(shift_q[7:1])) begin
                        // extension code interrupts at the eighth clock in both timings
                        kind_q <= KIND_EXT;
                        exc_q <= 1'b1;
                        trc_q <= 1'b0;
                        ack_drv_q <= acke;
                        irq_q <= 1'b1;
                        hold_q <= 1'b1;
                    end else if (involved) begin
                        kind_q <= KIND_MISS;
                        trc_q <= 1'b0;
                    end else begin
                        kind_q <= KIND_NONE;
                        trc_q <= 1'b0;
                    end
                end else if (involved) begin
                    std_q <= 1'b0;
                    ack_drv_q <= acke & ~trc_q;
                    if (!wtim) begin
                        irq_q <= 1'b1;
                        hold_q <= 1'b1;
                    end
                end
            end else if (scl_fall && cnt_q == `BIS_CNT_NINTH) begin
                ack_drv_q <= 1'b0;
                if (addr_phase_q) begin
                    case (kind_q)
                        KIND_MASTER, KIND_MATCH: begin
                            irq_q <= 1'b1;
                            hold_q <= 1'b1;
                        end
                        KIND_EXT: begin
                            if (wtim) begin
                                irq_q <= 1'b1;
                                hold_q <= 1'b1;
                            end
                        end
                        KIND_MISS: begin
                            // one report, then the frame is dropped: no data interrupts
                            irq_q <= 1'b1;
                            hold_q <= 1'b1;
                            kind_q <= KIND_NONE;
                        end
                        default: begin
                            kind_q <= KIND_NONE;
                        end
                    endcase
                end else if (involved && wtim) begin
                    irq_q <= 1'b1;
                    hold_q <= 1'b1;
                end
            end
        end
    end

    // ==========================================================================
    // open-drain drives; the hold starts a few cycles after the falling
    // edge because of the synchroniser, well inside the low phase
    assign scl_o = 1'b0;
    assign scl_oe_n_o = ~hold_q;
    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~ack_drv_q;
    assign reg_rdata_o = rdata_q;
    assign bus_event_irq_o = irq_q;

endmodule // bis_i2c_irq

// ---- verilog/bis_sync.v ----
// bis_sync.v: two-stage synchroniser for the two bus lines.
// assumes the line inputs are asynchronous to clock_i.
`timescale 1ns/10ps

module bis_sync (
    input wire clock_i,       // system clock
    input wire arst_n_i,      // async reset, active low
    input wire [1:0] async_i, // raw line levels
    output wire [1:0] sync_o  // synchronised levels
);

    reg [1:0] meta_q;
    reg [1:0] sync_q;

    // ==========================================================================
    // two flops; lines idle high, so reset to one
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= 2'h3;
            sync_q <= 2'h3;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule // bis_sync
